// ---- verification/cfp_fault_supervisor_assertions.sv ----
// port-level checker for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module cfp_sup_chk
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // watched ports
  input wire logic i_input_peak_limit,
  input wire logic i_thermal_shutdown_threshold,
  input wire logic i_zero_current_detect,
  input wire logic o_high_side_gate_drive_en,
  input wire logic o_low_side_gate_drive_en,
  input wire logic o_low_side_gate_drive_force,
  input wire logic o_voltage_loop_comp_node_pull_low,
  input wire logic o_forced_continuous_mode,
  input wire logic o_zero_current_detect_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_zcd_seen;
    o_low_side_gate_drive_force ##0 i_zero_current_detect [*3];
  endsequence
  sequence s_limit_held;
    i_input_peak_limit [*4];
  endsequence
  property p_zcd_en;
    o_zero_current_detect_en == !o_forced_continuous_mode;
  endproperty
  property p_comp;
    o_voltage_loop_comp_node_pull_low |-> o_forced_continuous_mode || $past(o_forced_continuous_mode);
  endproperty
  property p_trip;
    $rose(o_low_side_gate_drive_force) |-> !o_high_side_gate_drive_en;
  endproperty
  property p_zcd_end;
    s_zcd_seen |-> ##[1:2] !o_low_side_gate_drive_force;
  endproperty
  property p_limit;
    s_limit_held |-> !o_high_side_gate_drive_en;
  endproperty
  property p_thermal;
    i_thermal_shutdown_threshold [*4] |-> !o_high_side_gate_drive_en && !o_low_side_gate_drive_en;
  endproperty
  property p_excl;
    !(o_high_side_gate_drive_en && o_low_side_gate_drive_force);
  endproperty
  property p_stop;
    $fell(o_low_side_gate_drive_force) |-> !o_high_side_gate_drive_en && !o_low_side_gate_drive_en;
  endproperty
  a_zcd_en: assert property (p_zcd_en) else $error("zcd enable wrong");
  a_comp: assert property (p_comp) else $error("comp pull low outside forced_continuous_mode");
  a_trip: assert property (p_trip) else $error("high side on at trip");
  a_zcd_end: assert property (p_zcd_end) else $error("force held past zcd");
  a_limit: assert property (p_limit) else $error("high side on under limit");
  a_thermal: assert property (p_thermal) else $error("drive on over temp");
  a_excl: assert property (p_excl) else $error("high side with forced low");
  a_stop: assert property (p_stop) else $error("drive on after discharge");
endmodule : cfp_sup_chk
bind cfp_fault_supervisor cfp_sup_chk u_cfp_sup_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_input_peak_limit(i_input_peak_limit),
  .i_thermal_shutdown_threshold(i_thermal_shutdown_threshold),
  .i_zero_current_detect(i_zero_current_detect),
  .o_high_side_gate_drive_en(o_high_side_gate_drive_en),
  .o_low_side_gate_drive_en(o_low_side_gate_drive_en),
  .o_low_side_gate_drive_force(o_low_side_gate_drive_force),
  .o_voltage_loop_comp_node_pull_low(o_voltage_loop_comp_node_pull_low),
  .o_forced_continuous_mode(o_forced_continuous_mode),
  .o_zero_current_detect_en(o_zero_current_detect_en));
`default_nettype wire

// ---- verification/cfp_power_stage_model.sv ----
// power stage model: inductor current reaches zero some cycles into forced discharge
`timescale 1ns/1ps
`default_nettype none
module cfp_power_stage_model
#(
  parameter int ZCD_DELAY = 4
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // gate drive
  input wire logic i_low_side_gate_drive_force,
  input wire logic i_high_side_gate_drive_en,
  // current sense
  output logic o_zero_current_detect
);
  int cnt;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt <= 0;
      o_zero_current_detect <= 1'b0;
    end
    else if (i_high_side_gate_drive_en)
    begin
      cnt <= 0;
      o_zero_current_detect <= 1'b0;
    end
    else if (i_low_side_gate_drive_force)
    begin
      cnt <= cnt + 1;
      o_zero_current_detect <= (cnt >= ZCD_DELAY);
    end
  end
endmodule : cfp_power_stage_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cfp_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A; // arbitrary value
  logic clk = 0, rst_n = 0, scl = 1, sda_h = 1;
  logic oc1 = 0, oc2 = 0, pk = 0, av = 0, overvoltage_trip = 0, bmin = 0, ot = 0, hyst = 0;
  wire sda_w, sda_oe, sda_o, zero_current_detect, hs, ls, lf, cpl, forced_continuous_mode, zen;
  wire [FREQ_W-1:0] freq;
  wire [7:0] th1, th2, pth, minl;
  wire [15:0] avg;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  assign sda_w = sda_h & ~sda_oe;
  cfp_fault_supervisor #(.LATCHED_OFF(1'b1), .DEVICE_ADDR(DEV)) u_cfp_fault_supervisor (
    .i_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_o),
    .o_sda_oe(sda_oe), .i_overcurrent_detector_one(oc1), .i_overcurrent_detector_two(oc2),
    .i_input_peak_limit(pk), .i_input_avg_limit(av), .i_input_overvoltage_trip(overvoltage_trip),
    .i_input_below_minimum(bmin), .i_thermal_shutdown_threshold(ot),
    .i_temp_below_hysteresis(hyst), .i_zero_current_detect(zero_current_detect),
    .o_high_side_gate_drive_en(hs), .o_low_side_gate_drive_en(ls),
    .o_low_side_gate_drive_force(lf), .o_voltage_loop_comp_node_pull_low(cpl),
    .o_forced_continuous_mode(forced_continuous_mode), .o_zero_current_detect_en(zen), .o_freq_select(freq),
    .o_oc_one_threshold(th1), .o_oc_two_threshold(th2), .o_input_peak_threshold(pth),
    .o_input_avg_threshold(avg), .o_min_input_level(minl));
  cfp_power_stage_model #(.ZCD_DELAY(4)) u_cfp_power_stage_model (.i_clk(clk),
    .i_reset_n(rst_n), .i_low_side_gate_drive_force(lf), .i_high_side_gate_drive_en(hs),
    .o_zero_current_detect(zero_current_detect));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task bit_out(input logic b);
    sda_h <= b;
    tick(3);
    scl <= 1'b1;
    tick(5);
    scl <= 1'b0;
    tick(3);
  endtask : bit_out
  task bit_in(output logic b);
    sda_h <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    b = sda_w;
    tick(2);
    scl <= 1'b0;
    tick(3);
  endtask : bit_in
  task byte_out(input logic [7:0] v);
    logic ack;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(ack);
    chk("ack", 16'h0000, ack);
  endtask : byte_out
  task start_bit;
    sda_h <= 1'b0;
    tick(5);
    scl <= 1'b0;
    tick(3);
  endtask : start_bit
  task stop_bit;
    sda_h <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(5);
    sda_h <= 1'b1;
    tick(8);
  endtask : stop_bit
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    start_bit();
    byte_out({DEV, 1'b0});
    byte_out(a);
    byte_out(d);
    stop_bit();
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    start_bit();
    byte_out({DEV, 1'b0});
    byte_out(a);
    tick(3);
    scl <= 1'b1;
    tick(5);
    start_bit();
    byte_out({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop_bit();
  endtask : reg_rd
  task t_defaults;
    chk("forced_continuous_mode", 16'h0000, forced_continuous_mode);
    chk("zcd_en", 16'h0001, zen);
    chk("freq", 16'h0000, freq);
    chk("avg", 16'hFFFF, avg);
    chk("hs", 16'h0001, hs);
    chk("sda_out", 16'h0000, sda_o);
    chk("th1", 16'h00FF, th1);
    chk("th2", 16'h00FF, th2);
    chk("minl", 16'h0000, minl);
  endtask : t_defaults
  task t_regs_mode;
    logic [7:0] rd;
    reg_wr(8'h06, 8'h34);
    reg_wr(8'h07, 8'h12);
    reg_wr(8'h0A, 8'h77);
    reg_wr(8'h0D, 8'h85);
    reg_rd(8'h0A, rd);
    chk("rd_peak", 16'h0077, rd);
    chk("avg", 16'h1234, avg);
    chk("peak", 16'h0077, pth);
    chk("forced_continuous_mode", 16'h0001, forced_continuous_mode);
    chk("zcd_en", 16'h0000, zen);
    chk("freq", 16'h0005, freq);
    bmin <= 1'b1;
    tick(6);
    chk("comp", 16'h0001, cpl);
    bmin <= 1'b0;
  endtask : t_regs_mode
  task t_limits;
    pk <= 1'b1;
    tick(6);
    chk("hs_peak", 16'h0000, hs);
    pk <= 1'b0;
    av <= 1'b1;
    tick(6);
    chk("hs_avg", 16'h0000, hs);
    av <= 1'b0;
    tick(6);
    chk("hs_free", 16'h0001, hs);
  endtask : t_limits
  task t_oc;
    reg_wr(8'h28, 8'h10);
    oc2 <= 1'b1;
    tick(10);
    chk("hs_oc2_off", 16'h0001, hs);
    oc2 <= 1'b0;
    reg_wr(8'h23, 8'h01);
    oc1 <= 1'b1;
    tick(80);
    chk("hs_oc_wait", 16'h0001, hs);
    tick(26);
    chk("force_oc", 16'h0001, lf);
    tick(14);
    chk("hs_oc_trip", 16'h0000, hs);
    chk("ls_oc_stop", 16'h0000, ls);
    oc1 <= 1'b0;
    tick(20);
    chk("hs_latched", 16'h0000, hs);
    reg_wr(8'h0E, 8'h80);
    chk("hs_resume", 16'h0001, hs);
    chk("freq_reset", 16'h0000, freq);
  endtask : t_oc
  task t_ovp;
    overvoltage_trip <= 1'b1;
    tick(10);
    chk("hs_ovp_off", 16'h0001, hs);
    reg_wr(8'h0C, 8'h80);
    chk("hs_ovp", 16'h0000, hs);
    overvoltage_trip <= 1'b0;
    reg_wr(8'h0E, 8'h80);
    chk("hs_ovp_clr", 16'h0001, hs);
  endtask : t_ovp
  task t_thermal;
    ot <= 1'b1;
    tick(6);
    chk("ls_ot", 16'h0000, ls);
    ot <= 1'b0;
    hyst <= 1'b1;
    tick(20);
    chk("hs_ot_held", 16'h0000, hs);
    reg_wr(8'h0E, 8'h80);
    chk("hs_ot_clr", 16'h0001, hs);
  endtask : t_thermal
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    tick(16);
    rst_n <= 1'b1;
    tick(5);
    t_defaults();
    t_regs_mode();
    t_limits();
    t_oc();
    t_ovp();
    t_thermal();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/cfp_fault_supervisor.sv ----
// fault supervisor top: two-wire register slave, detectors and drive control
`timescale 1ns/1ps
`default_nettype none

module cfp_fault_supervisor
  import cfp_pkg::*;
#(
  parameter bit LATCHED_OFF = 1'b1,
  parameter logic [6:0] DEVICE_ADDR = 7'h2A // arbitrary value
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // two-wire register port
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // analog detector inputs
  input wire logic i_overcurrent_detector_one,
  input wire logic i_overcurrent_detector_two,
  input wire logic i_input_peak_limit,
  input wire logic i_input_avg_limit,
  input wire logic i_input_overvoltage_trip,
  input wire logic i_input_below_minimum,
  input wire logic i_thermal_shutdown_threshold,
  input wire logic i_temp_below_hysteresis,
  input wire logic i_zero_current_detect,
  // gate drive stage and analog control
  output logic o_high_side_gate_drive_en,
  output logic o_low_side_gate_drive_en,
  output logic o_low_side_gate_drive_force,
  output logic o_voltage_loop_comp_node_pull_low,
  output logic o_forced_continuous_mode,
  output logic o_zero_current_detect_en,
  output logic [FREQ_W-1:0] o_freq_select,
  output logic [7:0] o_oc_one_threshold,
  output logic [7:0] o_oc_two_threshold,
  output logic [7:0] o_input_peak_threshold,
  output logic [15:0] o_input_avg_threshold,
  output logic [7:0] o_min_input_level
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_a <= {2'b11, {(NSYNC-2){1'b0}}};
      sync_b <= {2'b11, {(NSYNC-2){1'b0}}};
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      sync_a <= {i_scl, i_sda, i_overcurrent_detector_one, i_overcurrent_detector_two,
                 i_input_peak_limit, i_input_avg_limit, i_input_overvoltage_trip,
                 i_input_below_minimum, i_thermal_shutdown_threshold,
                 i_temp_below_hysteresis, i_zero_current_detect};
      sync_b <= sync_a;
      scl_d <= sync_b[10];
      sda_d <= sync_b[9];
    end
  end

  wire scl_s = sync_b[10];
  wire sda_s = sync_b[9];
  wire oc1_cmp = sync_b[8];
  wire oc2_cmp = sync_b[7];
  wire peak_cmp = sync_b[6];
  wire avg_cmp = sync_b[5];
  wire vin_ovp_cmp = sync_b[4];
  wire vin_low = sync_b[3];
  wire over_temp = sync_b[2];
  wire temp_cool = sync_b[1];
  wire zero_current_detect = sync_b[0];

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire bus_start = scl_s && scl_d && sda_d && !sda_s;
  wire bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  cfp_reg_if rif ();

  cfp_regs u_regs (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .rif(rif)
  );

  // ----------------------------------------------------------------
  // two-wire slave
  // ----------------------------------------------------------------
  cfp_bus_state_t bus_state;
  cfp_bus_state_t next_bus_state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic byte_full;
  logic read_mode;
  logic [7:0] pointer;
  logic master_nack;

  wire addr_match = shreg[7:1] == DEVICE_ADDR;
  wire in_rx = bus_state == BUS_ADDR || bus_state == BUS_REG || bus_state == BUS_WDATA;

  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: next_bus_state = BUS_IDLE;
      BUS_ADDR:
        if (scl_fall && byte_full)
          next_bus_state = addr_match ? BUS_ACK_ADDR : BUS_IDLE;
      BUS_ACK_ADDR:
        if (scl_fall)
          next_bus_state = read_mode ? BUS_RDATA : BUS_REG;
      BUS_REG:
        if (scl_fall && byte_full)
          next_bus_state = BUS_ACK_REG;
      BUS_ACK_REG:
        if (scl_fall)
          next_bus_state = BUS_WDATA;
      BUS_WDATA:
        if (scl_fall && byte_full)
          next_bus_state = BUS_ACK_W;
      BUS_ACK_W:
        if (scl_fall)
          next_bus_state = BUS_WDATA;
      BUS_RDATA:
        if (scl_fall && bit_cnt == 3'd7)
          next_bus_state = BUS_ACK_R;
      BUS_ACK_R:
        if (scl_fall)
          next_bus_state = master_nack ? BUS_IDLE : BUS_RDATA;
      default: next_bus_state = BUS_IDLE;
    endcase
    if (bus_start)
      next_bus_state = BUS_ADDR;
    else if (bus_stop)
      next_bus_state = BUS_IDLE;
  end

  wire load_rd = bus_state != BUS_RDATA && next_bus_state == BUS_RDATA;
  wire data_wr = bus_state == BUS_WDATA && next_bus_state == BUS_ACK_W;
  wire data_rd = bus_state == BUS_RDATA && next_bus_state == BUS_ACK_R;
  wire ptr_load = bus_state == BUS_REG && next_bus_state == BUS_ACK_REG;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      bus_state <= BUS_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 3'd0;
      byte_full <= 1'b0;
      read_mode <= 1'b0;
      master_nack <= 1'b0;
    end
    else
    begin
      bus_state <= next_bus_state;
      if (next_bus_state != bus_state)
      begin
        bit_cnt <= 3'd0;
        byte_full <= 1'b0;
      end
      else if ((in_rx && scl_rise) || (bus_state == BUS_RDATA && scl_fall))
      begin
        bit_cnt <= bit_cnt + 3'd1;
        byte_full <= bit_cnt == 3'd7;
      end
      if (load_rd)
        shreg <= rif.rd_data;
      else if (in_rx && scl_rise)
        shreg <= {shreg[6:0], sda_s};
      else if (bus_state == BUS_RDATA && scl_fall)
        shreg <= {shreg[6:0], 1'b0};
      if (bus_state == BUS_ADDR && scl_fall && byte_full)
        read_mode <= shreg[0];
      if (bus_state == BUS_ACK_R && scl_rise)
        master_nack <= sda_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pointer <= 8'h00;
    else if (ptr_load)
      pointer <= shreg;
    else if (data_wr || data_rd)
      pointer <= pointer + 8'h01;
  end

  // open-drain data line, only ever pulled low
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_sda_oe <= 1'b0;
    else if (next_bus_state == BUS_ACK_ADDR || next_bus_state == BUS_ACK_REG
             || next_bus_state == BUS_ACK_W)
      o_sda_oe <= 1'b1;
    else if (next_bus_state == BUS_RDATA)
      o_sda_oe <= load_rd ? !rif.rd_data[7] : (scl_fall ? !shreg[6] : o_sda_oe);
    else
      o_sda_oe <= 1'b0;
  end

  assign o_sda_out = 1'b0;
  assign rif.wr_en = data_wr;
  assign rif.addr = pointer;
  assign rif.wr_data = shreg;

  // ----------------------------------------------------------------
  // overcurrent detectors with delay qualification
  // ----------------------------------------------------------------
  function automatic logic [15:0] cfp_delay_limit(input logic [7:0] code);
    cfp_delay_limit = 16'(code) * 16'(OC_DELAY_UNIT_CYC);
  endfunction : cfp_delay_limit

  logic [15:0] oc1_cnt;
  logic [15:0] oc2_cnt;
  wire oc1_en = rif.oc_en[OC1_EN_BIT];
  wire oc2_en = rif.oc_en[OC2_EN_BIT];
  wire [15:0] oc1_lim = cfp_delay_limit(rif.oc1_b);
  wire [15:0] oc2_lim = cfp_delay_limit(rif.oc2_b);
  wire oc1_trip = oc1_en && oc1_cmp && oc1_cnt >= oc1_lim;
  wire oc2_trip = oc2_en && oc2_cmp && oc2_cnt >= oc2_lim;
  wire oc_trip = oc1_trip || oc2_trip;
  wire ovp_trip = rif.ovp_ctrl[OVP_EN_BIT] && vin_ovp_cmp;
  wire forced_continuous_mode = rif.freq_mode[FORCED_CONTINUOUS_MODE_BIT];

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      oc1_cnt <= 16'h0000;
      oc2_cnt <= 16'h0000;
    end
    else
    begin
      oc1_cnt <= (oc1_en && oc1_cmp) ? (oc1_trip ? oc1_cnt : oc1_cnt + 16'h0001) : 16'h0000;
      oc2_cnt <= (oc2_en && oc2_cmp) ? (oc2_trip ? oc2_cnt : oc2_cnt + 16'h0001) : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // fault latches, set wins over clear
  // ----------------------------------------------------------------
  logic oc_latch;
  logic ovp_latch;
  logic ot_latch;
  cfp_pwr_state_t pwr_state;
  cfp_pwr_state_t next_pwr_state;

  wire oc_clear = LATCHED_OFF ? rif.sw_reset : !(oc1_cmp || oc2_cmp);
  wire ot_clear = temp_cool && (LATCHED_OFF ? rif.sw_reset : 1'b1);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      oc_latch <= 1'b0;
      ovp_latch <= 1'b0;
      ot_latch <= 1'b0;
    end
    else
    begin
      oc_latch <= oc_trip || (oc_latch && !oc_clear);
      ovp_latch <= ovp_trip || (ovp_latch && !(rif.sw_reset || !vin_ovp_cmp));
      ot_latch <= over_temp || (ot_latch && !ot_clear);
    end
  end

  // ----------------------------------------------------------------
  // power stage control
  // ----------------------------------------------------------------
  wire any_latch = oc_latch || ovp_latch || ot_latch;

  always_comb
  begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_RUN:
        if (over_temp)
          next_pwr_state = PWR_STOPPED;
        else if (oc_trip || ovp_trip)
          next_pwr_state = PWR_DISCHARGE;
      PWR_DISCHARGE:
        if (over_temp || zero_current_detect)
          next_pwr_state = PWR_STOPPED;
      PWR_STOPPED:
        if (!any_latch && !over_temp && !oc_trip && !ovp_trip)
          next_pwr_state = PWR_RUN;
      default: next_pwr_state = PWR_STOPPED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pwr_state <= PWR_RUN;
      o_high_side_gate_drive_en <= 1'b0;
      o_low_side_gate_drive_en <= 1'b0;
      o_low_side_gate_drive_force <= 1'b0;
      o_voltage_loop_comp_node_pull_low <= 1'b0;
    end
    else
    begin
      pwr_state <= next_pwr_state;
      o_high_side_gate_drive_en <= next_pwr_state == PWR_RUN && !peak_cmp && !avg_cmp;
      o_low_side_gate_drive_en <= next_pwr_state != PWR_STOPPED;
      o_low_side_gate_drive_force <= next_pwr_state == PWR_DISCHARGE;
      o_voltage_loop_comp_node_pull_low <= forced_continuous_mode && vin_low;
    end
  end

  // ----------------------------------------------------------------
  // status readback and analog settings
  // ----------------------------------------------------------------
  assign rif.status = {ot_latch, ovp_latch, oc_latch, peak_cmp || avg_cmp,
                       o_voltage_loop_comp_node_pull_low, 1'b0, pwr_state};
  assign o_forced_continuous_mode = forced_continuous_mode;
  assign o_zero_current_detect_en = !forced_continuous_mode;
  assign o_freq_select = rif.freq_mode[FREQ_LSB +: FREQ_W];
  assign o_oc_one_threshold = rif.oc1_a;
  assign o_oc_two_threshold = rif.oc2_a;
  assign o_input_peak_threshold = rif.peak;
  assign o_input_avg_threshold = {rif.avg_b, rif.avg_a};
  assign o_min_input_level = rif.min_vin;

endmodule : cfp_fault_supervisor

`default_nettype wire

// ---- verilog/cfp_pkg.sv ----
// constants, register map and state types of the converter fault supervisor
package cfp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MIN_VIN = 8'h05;
  localparam logic [7:0] ADDR_AVG_A = 8'h06;
  localparam logic [7:0] ADDR_AVG_B = 8'h07;
  localparam logic [7:0] ADDR_PEAK = 8'h0A;
  localparam logic [7:0] ADDR_OVP_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_FREQ_MODE = 8'h0D;
  localparam logic [7:0] ADDR_SOFT_RST = 8'h0E;
  localparam logic [7:0] ADDR_OC1_A = 8'h22;
  localparam logic [7:0] ADDR_OC1_B = 8'h23;
  localparam logic [7:0] ADDR_OC2_A = 8'h26;
  localparam logic [7:0] ADDR_OC2_B = 8'h27;
  localparam logic [7:0] ADDR_OC_EN = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h3F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OVP_EN_BIT = 7;
  localparam int FORCED_CONTINUOUS_MODE_BIT = 7;
  localparam int FREQ_LSB = 0;
  localparam int FREQ_W = 3;
  localparam int SOFT_RST_BIT = 7;
  localparam int OC1_EN_BIT = 4;
  localparam int OC2_EN_BIT = 5;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MIN_VIN = 8'h00;
  localparam logic [7:0] RST_AVG_A = 8'hFF;
  localparam logic [7:0] RST_AVG_B = 8'hFF;
  localparam logic [7:0] RST_PEAK = 8'hFF;
  localparam logic [7:0] RST_OVP_CTRL = 8'h00;
  localparam logic [7:0] RST_FREQ_MODE = 8'h00;
  localparam logic [7:0] RST_SOFT_RST = 8'h00;
  localparam logic [7:0] RST_OC1_A = 8'hFF;
  localparam logic [7:0] RST_OC1_B = 8'h00;
  localparam logic [7:0] RST_OC2_A = 8'hFF;
  localparam logic [7:0] RST_OC2_B = 8'h00;
  localparam logic [7:0] RST_OC_EN = 8'h30;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OC_DELAY_UNIT_NS = 1000;
  localparam int OC_DELAY_UNIT_CYC = (OC_DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0000,
    BUS_ADDR = 4'b0001,
    BUS_ACK_ADDR = 4'b0011,
    BUS_REG = 4'b0010,
    BUS_ACK_REG = 4'b0110,
    BUS_WDATA = 4'b0111,
    BUS_ACK_W = 4'b0101,
    BUS_RDATA = 4'b0100,
    BUS_ACK_R = 4'b1100
  } cfp_bus_state_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_DISCHARGE = 2'b01,
    PWR_STOPPED = 2'b11
  } cfp_pwr_state_t;

endpackage : cfp_pkg

// ---- verilog/cfp_reg_if.sv ----
// register file carrier between the supervisor core and its register store
`timescale 1ns/1ps
`default_nettype none

interface cfp_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] status;
  logic sw_reset;
  logic [7:0] min_vin;
  logic [7:0] avg_a;
  logic [7:0] avg_b;
  logic [7:0] peak;
  logic [7:0] ovp_ctrl;
  logic [7:0] freq_mode;
  logic [7:0] oc1_a;
  logic [7:0] oc1_b;
  logic [7:0] oc2_a;
  logic [7:0] oc2_b;
  logic [7:0] oc_en;

  modport store (
    input wr_en, addr, wr_data, status,
    output rd_data, sw_reset, min_vin, avg_a, avg_b, peak, ovp_ctrl, freq_mode,
    output oc1_a, oc1_b, oc2_a, oc2_b, oc_en
  );
  modport core (
    output wr_en, addr, wr_data, status,
    input rd_data, sw_reset, min_vin, avg_a, avg_b, peak, ovp_ctrl, freq_mode,
    input oc1_a, oc1_b, oc2_a, oc2_b, oc_en
  );
endinterface : cfp_reg_if

`default_nettype wire

// ---- verilog/cfp_regs.sv ----
// register store with registered read data and software reset
`timescale 1ns/1ps
`default_nettype none

module cfp_regs
  import cfp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // carrier
  cfp_reg_if.store rif
);

  logic [7:0] soft_rst;
  logic [7:0] next_rd_data;
  wire wr_soft_reset = rif.wr_en && rif.addr == ADDR_SOFT_RST && rif.wr_data[SOFT_RST_BIT];

  // ----------------------------------------------------------------
  // read decode, unmapped reads as zero
  // ----------------------------------------------------------------
  always_comb
  begin
    case (rif.addr)
      ADDR_MIN_VIN: next_rd_data = rif.min_vin;
      ADDR_AVG_A: next_rd_data = rif.avg_a;
      ADDR_AVG_B: next_rd_data = rif.avg_b;
      ADDR_PEAK: next_rd_data = rif.peak;
      ADDR_OVP_CTRL: next_rd_data = rif.ovp_ctrl;
      ADDR_FREQ_MODE: next_rd_data = rif.freq_mode;
      ADDR_SOFT_RST: next_rd_data = soft_rst;
      ADDR_OC1_A: next_rd_data = rif.oc1_a;
      ADDR_OC1_B: next_rd_data = rif.oc1_b;
      ADDR_OC2_A: next_rd_data = rif.oc2_a;
      ADDR_OC2_B: next_rd_data = rif.oc2_b;
      ADDR_OC_EN: next_rd_data = rif.oc_en;
      ADDR_STATUS: next_rd_data = rif.status;
      default: next_rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // storage; a set reset bit self-clears and restores defaults
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rif.sw_reset <= 1'b0;
      rif.rd_data <= 8'h00;
    end
    else
    begin
      rif.sw_reset <= wr_soft_reset;
      rif.rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rif.min_vin <= RST_MIN_VIN;
      rif.avg_a <= RST_AVG_A;
      rif.avg_b <= RST_AVG_B;
      rif.peak <= RST_PEAK;
      rif.ovp_ctrl <= RST_OVP_CTRL;
      rif.freq_mode <= RST_FREQ_MODE;
      soft_rst <= RST_SOFT_RST;
      rif.oc1_a <= RST_OC1_A;
      rif.oc1_b <= RST_OC1_B;
      rif.oc2_a <= RST_OC2_A;
      rif.oc2_b <= RST_OC2_B;
      rif.oc_en <= RST_OC_EN;
    end
    else if (rif.sw_reset)
    begin
      rif.min_vin <= RST_MIN_VIN;
      rif.avg_a <= RST_AVG_A;
      rif.avg_b <= RST_AVG_B;
      rif.peak <= RST_PEAK;
      rif.ovp_ctrl <= RST_OVP_CTRL;
      rif.freq_mode <= RST_FREQ_MODE;
      soft_rst <= RST_SOFT_RST;
      rif.oc1_a <= RST_OC1_A;
      rif.oc1_b <= RST_OC1_B;
      rif.oc2_a <= RST_OC2_A;
      rif.oc2_b <= RST_OC2_B;
      rif.oc_en <= RST_OC_EN;
    end
    else if (rif.wr_en)
    begin
      case (rif.addr)
        ADDR_MIN_VIN: rif.min_vin <= rif.wr_data;
        ADDR_AVG_A: rif.avg_a <= rif.wr_data;
        ADDR_AVG_B: rif.avg_b <= rif.wr_data;
        ADDR_PEAK: rif.peak <= rif.wr_data;
        ADDR_OVP_CTRL: rif.ovp_ctrl <= rif.wr_data;
        ADDR_FREQ_MODE: rif.freq_mode <= rif.wr_data;
        ADDR_SOFT_RST: soft_rst <= {1'b0, rif.wr_data[6:0]};
        ADDR_OC1_A: rif.oc1_a <= rif.wr_data;
        ADDR_OC1_B: rif.oc1_b <= rif.wr_data;
        ADDR_OC2_A: rif.oc2_a <= rif.wr_data;
        ADDR_OC2_B: rif.oc2_b <= rif.wr_data;
        ADDR_OC_EN: rif.oc_en <= rif.wr_data;
        default: soft_rst <= soft_rst;
      endcase
    end
  end

endmodule : cfp_regs

`default_nettype wire
